// *** rtl/smrap_pkg.sv ***
// Purpose: shared constants, types and carriers for the serial memory / clock register command block
// Assumes: 32K x 8 array, 16 clock registers, serial framing sampled by the system clock
// Notes:   opcode values form one editable set; change them here only

package smrap_pkg;

  // ********************************
  // opcodes (one configurable set)
  // ********************************
  localparam logic [7:0] OP_SET_WRITE_LATCH     = 8'h06;
  localparam logic [7:0] OP_CLR_WRITE_LATCH     = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE        = 8'h01;
  localparam logic [7:0] OP_MEM_READ            = 8'h03;
  localparam logic [7:0] OP_MEM_FAST_READ       = 8'h0B;
  localparam logic [7:0] OP_MEM_WRITE           = 8'h02;
  localparam logic [7:0] OP_CLOCK_REG_READ      = 8'h13;
  localparam logic [7:0] OP_CLOCK_REG_FAST_READ = 8'h1D;
  localparam logic [7:0] OP_CLOCK_REG_WRITE     = 8'h12;

  // ********************************
  // status byte layout
  // ********************************
  localparam int SR_PIN_PROTECT_BIT = 7;
  localparam int SR_SERIAL_LOCK_BIT = 6;
  localparam int SR_GUARD_HIGH_BIT  = 3;
  localparam int SR_GUARD_LOW_BIT   = 2;
  localparam logic [1:0] SR_RESET_GUARD = 2'h0;

  // ********************************
  // memory array and block guard map
  // ********************************
  localparam int MEM_AW    = 15;
  localparam int MEM_DEPTH = 32768;
  localparam logic [MEM_AW-1:0] MEM_TOP        = 15'h7FFF;
  localparam logic [MEM_AW-1:0] GUARD_QTR_BASE = 15'h6000;
  localparam logic [MEM_AW-1:0] GUARD_HALF_BASE = 15'h4000;
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QTR  = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  localparam logic [1:0] GUARD_ALL  = 2'h3;

  // ********************************
  // clock register file
  // ********************************
  localparam int RTC_REGS = 16;
  localparam logic [3:0] RTC_LAST      = 4'hF;
  localparam logic [3:0] RTC_FLAGS_IDX = 4'h0;
  localparam int RTC_READ_HOLD_BIT  = 0;
  localparam int RTC_WRITE_HOLD_BIT = 1;

  typedef enum logic [2:0] {
    ST_OPCODE  = 3'b000,
    ST_ADDR_HI = 3'b001,
    ST_ADDR_LO = 3'b010,
    ST_DUMMY   = 3'b011,
    ST_RD_DATA = 3'b100,
    ST_WR_DATA = 3'b101,
    ST_IGNORE  = 3'b110
  } smrap_state_t;

  typedef enum logic [2:0] {
    K_NONE      = 3'b000,
    K_MEM_RD    = 3'b001,
    K_MEM_FAST  = 3'b010,
    K_MEM_WR    = 3'b011,
    K_RTC_RD    = 3'b100,
    K_RTC_FAST  = 3'b101,
    K_RTC_WR    = 3'b110,
    K_STATUS_WR = 3'b111
  } smrap_kind_t;

  typedef struct packed {
    logic       frame_start;
    logic       frame_end;
    logic       cs_active;
    logic       sck_fall;
    logic       byte_valid;
    logic [7:0] rx_byte;
    logic       wp_n;
  } smrap_rx_t;

endpackage : smrap_pkg

// *** rtl/smrap_spi_rx.sv ***
// Purpose: pin synchronisers, clock edge detection and byte assembly for the serial link
// Assumes: serial clock well below a quarter of the system clock
// Notes:   bits are sampled on serial clock rising edges, in either idle level

`timescale 1ns/10ps

module smrap_spi_rx
  import smrap_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  input  wire logic i_wp_n,
  output smrap_rx_t o_rx
);

  logic [3:0] meta;
  logic [3:0] sync;
  logic       sck_prev;
  logic       cs_n_prev;
  logic [2:0] bit_cnt;
  logic [6:0] shift;

  wire cs_low   = !sync[0];
  wire sck_now  = sync[1];
  wire si_now   = sync[2];
  wire sck_rise = cs_low && sck_now && !sck_prev;
  wire sck_fall = cs_low && !sck_now && sck_prev;

  // ********************************
  // two-stage sync and edges
  // ********************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      meta      <= 4'h9;
      sync      <= 4'h9;
      sck_prev  <= 1'b0;
      cs_n_prev <= 1'b1;
    end else if (i_ce) begin
      meta      <= {i_wp_n, i_si, i_sck, i_cs_n};
      sync      <= meta;
      sck_prev  <= sck_now;
      cs_n_prev <= sync[0];
    end
  end

  // ********************************
  // byte assembly, msb first
  // ********************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_rx    <= '0;
      bit_cnt <= 3'h0;
      shift   <= 7'h00;
    end else if (i_ce) begin
      o_rx.frame_start <= cs_n_prev && !sync[0];
      o_rx.frame_end   <= !cs_n_prev && sync[0];
      o_rx.cs_active   <= cs_low;
      o_rx.sck_fall    <= sck_fall;
      o_rx.wp_n        <= sync[3];
      o_rx.byte_valid  <= 1'b0;
      if (!cs_low) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        shift   <= {shift[5:0], si_now};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          o_rx.byte_valid <= 1'b1;
          o_rx.rx_byte    <= {shift, si_now};
        end
      end
    end
  end

endmodule : smrap_spi_rx

// *** rtl/smrap_core.sv ***
// Purpose: serial command handling for a 32K x 8 memory with a 16-entry clock register file
// Assumes: i_nv_busy comes from the store/recall engine on the same clock
// Notes:   serial clock must stay at or below about 1/8 of i_sys_clk
//
// Operation
// - pin low plus pin enable blocks status writes
// - pin enable clear ignores the protect pin
// - pin change mid-frame leaves status write alone
// - guarded blocks never written; others need latch
// - no memory commands while store is running
// - read: opcode, two address bytes, msb out
// - read streams on, wrapping 0x7FFF to 0x0000
// - fast read streams endlessly until select rises
// - write: latch set, address, bytes, wraps around
// - latch clears after memory write frame ends
// - guarded bytes dropped, address keeps counting
// - sixteen clock registers, wrap 0x0F to 0x00
// - clock read: opcode, address, data follows
// - fast clock read adds one dummy byte
// - time writes need write hold; load on release
// - clock write needs latch, latch clears after
// - guard codes: none, quarter, half, all
// - without latch write commands ignored till deselect
// - status write touches bits 2,3,6,7 only

`timescale 1ns/10ps

module smrap_core
  import smrap_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  input  wire logic       i_cs_n,
  input  wire logic       i_sck,
  input  wire logic       i_si,
  input  wire logic       i_wp_n,
  input  wire logic       i_nv_busy,
  output logic            o_so,
  output logic            o_so_oe,
  output logic [7:0]      o_status,
  output logic            o_hardware_store_pin_n,
  output logic            o_rtc_read_hold,
  output logic            o_rtc_write_hold,
  output logic            o_rtc_load
);

  smrap_rx_t          rx;
  smrap_state_t       state;
  smrap_kind_t        kind;
  logic [MEM_AW-1:0]  ptr;
  logic [2:0]         bitsel;
  logic               wen;
  logic               pin_protect_enable;
  logic               serial_lock_bit;
  logic               block_guard_high;
  logic               block_guard_low;
  logic               sr_lock;
  logic               wclass;
  logic               clr_at_end;
  logic [7:0]         mem [0:MEM_DEPTH-1];
  logic [7:0]         rtc [0:RTC_REGS-1];

  smrap_state_t       dec_state;
  smrap_kind_t        dec_kind;
  logic               dec_set_wen;
  logic               dec_clr_wen;
  logic               dec_wclass;

  smrap_spi_rx u_rx (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_cs_n    (i_cs_n),
    .i_sck     (i_sck),
    .i_si      (i_si),
    .i_wp_n    (i_wp_n),
    .o_rx      (rx)
  );

  // ********************************
  // decode and selection
  // ********************************
  wire [7:0]        rxb       = rx.rx_byte;
  wire              byte_in   = rx.byte_valid;
  wire [1:0]        guard     = {block_guard_high, block_guard_low};
  wire              is_rtc    = (kind == K_RTC_RD) || (kind == K_RTC_FAST) || (kind == K_RTC_WR);
  wire              is_fast   = (kind == K_MEM_FAST) || (kind == K_RTC_FAST);
  wire              is_write  = (kind == K_MEM_WR) || (kind == K_RTC_WR);
  wire [3:0]        rtc_idx   = ptr[3:0];
  wire [3:0]        rtc_inc   = rtc_idx + 4'h1;
  wire [MEM_AW-1:0] ptr_next  = is_rtc ? {{(MEM_AW-4){1'b0}}, rtc_inc} : ptr + 1'b1;
  wire              blk_prot  = (guard == GUARD_ALL)
                              || (guard == GUARD_HALF && ptr >= GUARD_HALF_BASE)
                              || (guard == GUARD_QTR && ptr >= GUARD_QTR_BASE);
  wire              wr_byte   = (state == ST_WR_DATA) && byte_in;
  wire              mem_we    = wr_byte && (kind == K_MEM_WR) && !blk_prot;
  wire              w_hold    = rtc[RTC_FLAGS_IDX][RTC_WRITE_HOLD_BIT];
  wire              rtc_we    = wr_byte && (kind == K_RTC_WR)
                              && (rtc_idx == RTC_FLAGS_IDX || w_hold);
  wire              sr_we     = wr_byte && (kind == K_STATUS_WR) && !sr_lock;
  wire [1:0]        sr_guard  = {rxb[SR_GUARD_HIGH_BIT], rxb[SR_GUARD_LOW_BIT]};
  wire              w_release = rtc_we && (rtc_idx == RTC_FLAGS_IDX) && w_hold
                              && !rxb[RTC_WRITE_HOLD_BIT];
  wire [7:0]        rd_byte   = is_rtc ? rtc[rtc_idx] : mem[ptr];
  wire              rd_fall   = (state == ST_RD_DATA) && rx.sck_fall;
  wire              mem_ok    = !i_nv_busy;

  always_comb begin
    dec_state   = ST_IGNORE;
    dec_kind    = K_NONE;
    dec_set_wen = 1'b0;
    dec_clr_wen = 1'b0;
    case (rxb)
      OP_SET_WRITE_LATCH: begin
        dec_set_wen = 1'b1;
      end
      OP_CLR_WRITE_LATCH: begin
        dec_clr_wen = 1'b1;
      end
      OP_STATUS_WRITE: begin
        dec_kind  = K_STATUS_WR;
        dec_state = wen ? ST_WR_DATA : ST_IGNORE;
      end
      OP_MEM_READ: begin
        dec_kind  = K_MEM_RD;
        dec_state = mem_ok ? ST_ADDR_HI : ST_IGNORE;
      end
      OP_MEM_FAST_READ: begin
        dec_kind  = K_MEM_FAST;
        dec_state = mem_ok ? ST_ADDR_HI : ST_IGNORE;
      end
      OP_MEM_WRITE: begin
        dec_kind  = K_MEM_WR;
        dec_state = (mem_ok && wen) ? ST_ADDR_HI : ST_IGNORE;
      end
      OP_CLOCK_REG_READ: begin
        dec_kind  = K_RTC_RD;
        dec_state = ST_ADDR_LO;
      end
      OP_CLOCK_REG_FAST_READ: begin
        dec_kind  = K_RTC_FAST;
        dec_state = ST_ADDR_LO;
      end
      OP_CLOCK_REG_WRITE: begin
        dec_kind  = K_RTC_WR;
        dec_state = wen ? ST_ADDR_LO : ST_IGNORE;
      end
      default: begin
        dec_state = ST_IGNORE;
      end
    endcase
  end

  assign dec_wclass = (dec_state != ST_IGNORE)
                    && (dec_kind == K_MEM_WR || dec_kind == K_RTC_WR || dec_kind == K_STATUS_WR);

  // ********************************
  // command sequencer
  // ********************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state      <= ST_OPCODE;
      kind       <= K_NONE;
      ptr        <= '0;
      bitsel     <= 3'h0;
      wen        <= 1'b0;
      sr_lock    <= 1'b0;
      wclass     <= 1'b0;
      clr_at_end <= 1'b0;
    end else if (i_ce) begin
      if (rx.frame_start) begin
        state      <= ST_OPCODE;
        bitsel     <= 3'h0;
        wclass     <= 1'b0;
        clr_at_end <= 1'b0;
        sr_lock    <= pin_protect_enable && !rx.wp_n;
      end else if (rx.frame_end) begin
        state <= ST_OPCODE;
        if (wclass || clr_at_end) begin
          wen <= 1'b0;
        end
      end else if (byte_in) begin
        case (state)
          ST_OPCODE: begin
            state      <= dec_state;
            kind       <= dec_kind;
            wclass     <= dec_wclass;
            clr_at_end <= dec_clr_wen;
            if (dec_set_wen) begin
              wen <= 1'b1;
            end
          end
          ST_ADDR_HI: begin
            ptr   <= {rxb[MEM_AW-9:0], ptr[7:0]};          // top address bit dropped
            state <= ST_ADDR_LO;
          end
          ST_ADDR_LO: begin
            ptr    <= is_rtc ? {{(MEM_AW-4){1'b0}}, rxb[3:0]} : {ptr[MEM_AW-1:8], rxb};
            bitsel <= 3'h0;
            state  <= is_fast ? ST_DUMMY : (is_write ? ST_WR_DATA : ST_RD_DATA);
          end
          ST_DUMMY: begin
            state <= ST_RD_DATA;
          end
          ST_WR_DATA: begin
            if (kind == K_STATUS_WR) begin
              state <= ST_IGNORE;
            end else begin
              ptr <= ptr_next;                            // guarded bytes still advance
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end else if (rd_fall) begin
        bitsel <= bitsel + 3'h1;
        if (bitsel == 3'h7) begin
          ptr <= ptr_next;
        end
      end
    end
  end

  // ********************************
  // status bits and serial output
  // ********************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      pin_protect_enable <= 1'b0;
      serial_lock_bit    <= 1'b0;
      {block_guard_high, block_guard_low} <= SR_RESET_GUARD;
    end else if (i_ce && sr_we) begin
      pin_protect_enable <= rxb[SR_PIN_PROTECT_BIT];
      serial_lock_bit    <= serial_lock_bit | rxb[SR_SERIAL_LOCK_BIT];
      block_guard_high   <= rxb[SR_GUARD_HIGH_BIT];
      block_guard_low    <= rxb[SR_GUARD_LOW_BIT];
    end
  end

  // first bit appears on the fall after the last header bit, so no extra latency
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_so                   <= 1'b0;
      o_so_oe                <= 1'b0;
      o_status               <= 8'h00;
      o_hardware_store_pin_n <= 1'b1;
    end else if (i_ce) begin
      o_so_oe <= (state == ST_RD_DATA) && rx.cs_active && !rx.frame_end;
      if (rd_fall) begin
        o_so <= rd_byte[3'h7 - bitsel];
      end
      o_status <= {pin_protect_enable, serial_lock_bit, 2'b00, block_guard_high, block_guard_low,
                   wen, i_nv_busy};
      o_hardware_store_pin_n <= !i_nv_busy;
    end
  end

  // ********************************
  // storage arrays
  // ********************************
  always_ff @(posedge i_sys_clk) begin
    if (i_ce && mem_we) begin
      mem[ptr] <= rxb;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      for (int i = 0; i < RTC_REGS; i++) begin
        rtc[i] <= 8'h00;
      end
      o_rtc_read_hold  <= 1'b0;
      o_rtc_write_hold <= 1'b0;
      o_rtc_load       <= 1'b0;
    end else if (i_ce) begin
      if (rtc_we) begin
        rtc[rtc_idx] <= rxb;
      end
      o_rtc_read_hold  <= rtc[RTC_FLAGS_IDX][RTC_READ_HOLD_BIT];
      o_rtc_write_hold <= w_hold;
      o_rtc_load       <= w_release;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn || !i_ce);

  property p_sr_locked;
    sr_lock && wr_byte && kind == K_STATUS_WR |=> $stable(guard) && $stable(pin_protect_enable);
  endproperty
  a_sr_locked: assert property (p_sr_locked) else $error("status changed while pin-locked");

  property p_sr_unlocked;
    wr_byte && kind == K_STATUS_WR && !pin_protect_enable
      |=> guard == $past(sr_guard);
  endproperty
  a_sr_unlocked: assert property (p_sr_unlocked) else $error("status write lost");

  property p_lock_steady;
    !rx.frame_start |=> $stable(sr_lock);
  endproperty
  a_lock_steady: assert property (p_lock_steady) else $error("lock moved inside frame");

  property p_no_guarded_write;
    mem_we |-> !blk_prot && wclass;
  endproperty
  a_no_guarded_write: assert property (p_no_guarded_write) else $error("guarded byte written");

  property p_mem_wrap;
    rd_fall && bitsel == 3'h7 && !is_rtc && ptr == MEM_TOP |=> ptr == '0;
  endproperty
  a_mem_wrap: assert property (p_mem_wrap) else $error("memory address did not wrap");

  property p_latch_clear;
    rx.frame_end && wclass |=> !wen ##1 !o_status[1];
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("write latch kept");

  property p_rtc_wrap;
    wr_byte && kind == K_RTC_WR && rtc_idx == RTC_LAST |=> ptr == '0;
  endproperty
  a_rtc_wrap: assert property (p_rtc_wrap) else $error("clock register index did not wrap");

  property p_no_latch_ignore;
    state == ST_OPCODE && byte_in && !rx.frame_end && !rx.frame_start && !wen
      && (rxb == OP_MEM_WRITE || rxb == OP_CLOCK_REG_WRITE || rxb == OP_STATUS_WRITE)
      |=> state == ST_IGNORE;
  endproperty
  a_no_latch_ignore: assert property (p_no_latch_ignore) else $error("write accepted without latch");

  property p_hold_needed;
    wr_byte && kind == K_RTC_WR && rtc_idx != RTC_FLAGS_IDX && !w_hold
      |=> rtc[$past(rtc_idx)] == $past(rd_byte);
  endproperty
  a_hold_needed: assert property (p_hold_needed) else $error("time written without hold");

  property p_load_pulse;
    w_release |=> o_rtc_load ##1 !o_rtc_write_hold;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("no load on hold release");

  c_fast_read:    cover property (state == ST_DUMMY ##[1:40] rd_fall && kind == K_MEM_FAST);
  c_guarded_skip: cover property (wr_byte && kind == K_MEM_WR && blk_prot);
  c_rtc_release:  cover property (w_release);

endmodule : smrap_core

// *** testbench/smrap_host_model.sv ***
// Purpose: host side serial controller model driving select, clock and data
// Assumes: one link bit every 8 system clocks, mode 0 or mode 3 framing
// Notes:   data line shows the inverse of its last bit while deselected
`timescale 1ns/10ps
module smrap_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  logic cpol;
  logic oe_seen;
  initial begin
    o_cs_n  = 1'b1;
    o_sck   = 1'b0;
    o_si    = 1'b0;
    cpol    = 1'b0;
    oe_seen = 1'b0;
  end
  always @(posedge i_sys_clk) if (!o_cs_n && i_so_oe === 1'b1) oe_seen <= 1'b1;
  // ****************
  // link tasks
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick
  task automatic start(input logic mode3);
    cpol  = mode3;
    o_sck = mode3;
    tick(2);
    oe_seen = 1'b0;
    o_cs_n  = 1'b0;
    tick(6);
  endtask : start
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sck = 1'b0;
      o_si  = tx[i];
      tick(4);
      o_sck = 1'b1;
      tick(4);
      rx[i] = i_so_oe ? i_so : ~i_so; // released line reads as inverse
    end
  endtask : xfer
  task automatic stop();
    if (!cpol) o_sck = 1'b0;
    tick(4);
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    tick(10);
  endtask : stop
endmodule : smrap_host_model

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the serial memory and clock register command block
// Assumes: host model runs the link at 320 ns per bit
// Notes:   memory expectation kept only for addresses the bench wrote
`timescale 1ns/10ps
module tb
  import smrap_pkg::*;
;
  logic       i_sys_clk, i_rstn, i_ce, i_wp_n, i_nv_busy, cs_n, sck, si;
  logic       o_so, o_so_oe, o_hardware_store_pin_n, o_rtc_read_hold, o_rtc_write_hold, o_rtc_load;
  logic [7:0] o_status, rx;
  logic [1:0] guard;
  logic [7:0] exp_mem [int];
  logic [7:0] got [$];
  int         fail_count = 0;
  int         n_checks = 0;
  int         load_cnt = 0;
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) if (o_rtc_load === 1'b1) load_cnt++;
  smrap_core smrap_core_inst (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .i_wp_n(i_wp_n), .i_nv_busy(i_nv_busy), .o_so(o_so), .o_so_oe(o_so_oe), .o_status(o_status),
    .o_hardware_store_pin_n(o_hardware_store_pin_n), .o_rtc_read_hold(o_rtc_read_hold),
    .o_rtc_write_hold(o_rtc_write_hold), .o_rtc_load(o_rtc_load));
  smrap_host_model host (.i_sys_clk(i_sys_clk), .i_so(o_so), .i_so_oe(o_so_oe), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si));
  // ****************
  // helpers
  // ****************
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  function automatic logic prot(input logic [14:0] a);
    return guard == 2'h3 || (guard == 2'h2 && a >= 15'h4000) || (guard == 2'h1 && a >= 15'h6000);
  endfunction : prot
  task automatic frame(input logic m3, input logic [7:0] tx [$], input int nrd);
    logic [7:0] r;
    got = {};
    host.start(m3);
    foreach (tx[i]) host.xfer(tx[i], r);
    // input during the data phase must be ignored
    repeat (nrd) begin
      host.xfer(8'hFF, r);
      got.push_back(r);
    end
    host.stop();
  endtask : frame
  task automatic set_write_latch_cmd();
    frame(1'b0, {OP_SET_WRITE_LATCH}, 0);
  endtask : set_write_latch_cmd
  task automatic sr_write(input logic [7:0] v);
    set_write_latch_cmd();
    frame(1'b0, {OP_STATUS_WRITE, v}, 0);
  endtask : sr_write
  task automatic mwr(input logic [15:0] a, input logic [7:0] v, input int n);
    logic [7:0] q [$];
    q = {OP_MEM_WRITE, a[15:8], a[7:0]};
    for (int k = 0; k < n; k++) begin
      q.push_back(v + 8'(k));
      if (!prot(a[14:0] + 15'(k))) exp_mem[int'(15'(a[14:0] + 15'(k)))] = v + 8'(k);
    end
    set_write_latch_cmd();
    frame(1'b0, q, 0);
    chk("wen", 8'h00, {7'h00, o_status[1]});
  endtask : mwr
  task automatic mrd(input logic [15:0] a, input int n, input logic fast);
    logic [7:0] q [$];
    q = {fast ? OP_MEM_FAST_READ : OP_MEM_READ, a[15:8], a[7:0]};
    if (fast) q.push_back(8'h00);
    frame(fast, q, n);
    for (int k = 0; k < n; k++) chk("mem", exp_mem[int'(15'(a[14:0] + 15'(k)))], got[k]);
  endtask : mrd
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    chk("status", 8'h00, o_status);
    chk("store_pin_n", 8'h01, {7'h00, o_hardware_store_pin_n});
    chk("holds", 8'h00, {5'h00, o_so_oe, o_rtc_read_hold, o_rtc_write_hold});
    $display("test reset done");
  endtask : t_reset
  task automatic t_status();
    set_write_latch_cmd();
    chk("wen", 8'h01, {7'h00, o_status[1]});
    frame(1'b0, {OP_CLR_WRITE_LATCH}, 0);
    chk("wen", 8'h00, {7'h00, o_status[1]});
    frame(1'b0, {OP_STATUS_WRITE, 8'h8C}, 0);
    chk("status", 8'h00, o_status);
    sr_write(8'hB7);
    chk("status", 8'h84, o_status);
    i_wp_n = 1'b0;
    sr_write(8'h80);
    chk("status", 8'h84, o_status);
    i_wp_n = 1'b1;
    set_write_latch_cmd();
    host.start(1'b0);
    host.xfer(OP_STATUS_WRITE, rx);
    i_wp_n = 1'b0;
    host.xfer(8'h88, rx);
    host.stop();
    chk("status", 8'h88, o_status);
    i_wp_n = 1'b1;
    sr_write(8'h08);
    i_wp_n = 1'b0;
    sr_write(8'h04);
    chk("status", 8'h04, o_status);
    i_wp_n = 1'b1;
    $display("test status done");
  endtask : t_status
  task automatic t_guard();
    for (int g = 0; g < 4; g++) begin
      guard = 2'(g);
      sr_write({4'h0, guard, 2'h0});
      chk("status", {4'h0, guard, 2'h0}, o_status);
      mwr(16'hBFFF, {guard, 6'h10}, 2);
      mwr(16'h5FFF, {guard, 6'h20}, 3);
      mwr(16'hFFFF, {guard, 6'h30}, 2);
      mrd(16'hBFFF, 2, guard[0]);
      mrd(16'h5FFF, 3, guard[1]);
      mrd(16'hFFFF, 2, 1'b0);
    end
    sr_write(8'h00);
    guard = 2'h0;
    frame(1'b0, {OP_MEM_WRITE, 8'h3F, 8'hFF, 8'hEE}, 0);
    mrd(16'h3FFF, 1, 1'b0);
    $display("test guard done");
  endtask : t_guard
  task automatic t_busy();
    i_nv_busy = 1'b1;
    host.tick(3);
    chk("busy", 8'h01, {7'h00, o_status[0]});
    chk("store_pin_n", 8'h00, {7'h00, o_hardware_store_pin_n});
    frame(1'b0, {OP_MEM_READ, 8'h3F, 8'hFF}, 1);
    chk("oe", 8'h00, {7'h00, host.oe_seen});
    set_write_latch_cmd();
    frame(1'b0, {OP_MEM_WRITE, 8'h3F, 8'hFF, 8'h77}, 0);
    i_nv_busy = 1'b0;
    host.tick(3);
    mrd(16'h3FFF, 1, 1'b1);
    chk("oe", 8'h01, {7'h00, host.oe_seen});
    $display("test busy done");
  endtask : t_busy
  task automatic t_rtc();
    int n;
    set_write_latch_cmd();
    frame(1'b1, {OP_CLOCK_REG_WRITE, 8'h06, 8'h33}, 0);
    set_write_latch_cmd();
    frame(1'b1, {OP_CLOCK_REG_WRITE, 8'h00, 8'h02}, 0);
    chk("write_hold", 8'h01, {7'h00, o_rtc_write_hold});
    set_write_latch_cmd();
    frame(1'b1, {OP_CLOCK_REG_WRITE, 8'h0F, 8'h5A, 8'h03}, 0);
    chk("holds", 8'h03, {6'h00, o_rtc_read_hold, o_rtc_write_hold});
    chk("wen", 8'h00, {7'h00, o_status[1]});
    frame(1'b1, {OP_CLOCK_REG_WRITE, 8'h0F, 8'h11}, 0);
    frame(1'b1, {OP_CLOCK_REG_READ, 8'h0F}, 3);
    chk("reg", 8'h5A, got[0]);
    chk("reg", 8'h03, got[1]);
    chk("reg", 8'h00, got[2]);
    frame(1'b0, {OP_CLOCK_REG_FAST_READ, 8'h06, 8'h00}, 1);
    chk("reg", 8'h00, got[0]);
    n = load_cnt;
    set_write_latch_cmd();
    frame(1'b1, {OP_CLOCK_REG_WRITE, 8'h00, 8'h00}, 0);
    chk("load", 8'h01, 8'(load_cnt - n));
    chk("holds", 8'h00, {6'h00, o_rtc_read_hold, o_rtc_write_hold});
    $display("test clock registers done");
  endtask : t_rtc
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  initial begin
    i_rstn    = 1'b0;
    i_ce      = 1'b1;
    i_wp_n    = 1'b1;
    i_nv_busy = 1'b0;
    guard     = 2'h0;
    repeat (3) @(posedge i_sys_clk);
    #1 i_rstn = 1'b1;
    host.tick(2);
    t_reset();
    t_status();
    t_guard();
    t_busy();
    t_rtc();
    test_done();
  end
  // nearly four times the expected run
  initial begin
    #(60000 * 40);
    fail_count++;
    $display("MISMATCH watchdog expected done seen hang");
    test_done();
  end
endmodule : tb
